// >>> hw/tlv_consts.svh
// Constants for the two-level vectored interrupt handler
// Behaviour
// - Sixteen sources, each assignable to low or high priority level.
// - Pending flag sets on its event whatever the enable state.
// - Enabled pending source requests; core finishes instruction then long-calls its vector.
// - Handler return resumes the instruction that would otherwise have run.
// - Pending flag of a disabled source makes no request.
// - Global enable bit 7 of enable register masks every source when zero.
// - Request seen while global enable clears may still be taken once.
// - Some flags cleared by hardware on vectoring, others by software.
// - Flag still set after return re-requests after one more instruction.
// - Software setting a pending flag acts exactly like a hardware event; here a level-sensed external flag drops the set and follows its input.
// - Per external input, sense bit selects edge or level, polarity bit selects level.
// - External inputs watch a configured port pin without disturbing the pin.
// - External pending flags sit at timer control bits 1 and 3.
// - Edge-sensed external flag clears by hardware on vectoring.
// - Level-sensed external flag follows the active input level.
// - Every source has its own enable bit.
// - Every source has its own priority bit, all low after reset.
// - High level preempts running low handler; high handler never preempted.
// - Higher level wins; equal level decided by fixed source order.
// - Vectors start at 0x0003 and rise by eight per source.
// - Requests sampled and decoded every clock cycle.
`ifndef TLV_CONSTS_SVH
`define TLV_CONSTS_SVH
`define TLV_NSRC          16
`define TLV_ADDR_EN       8'h00
`define TLV_ADDR_EXT_EN1  8'h04
`define TLV_ADDR_EXT_EN2  8'h08
`define TLV_ADDR_PRIO     8'h0c
`define TLV_ADDR_EXT_PRI1 8'h10
`define TLV_ADDR_EXT_PRI2 8'h14
`define TLV_ADDR_TMR_CTL  8'h18
`define TLV_ADDR_PIN_CFG  8'h1c
`define TLV_ADDR_PEND_SET 8'h20
`define TLV_ADDR_PEND_CLR 8'h24
`define TLV_ADDR_STATUS   8'h28
`define TLV_GEN_BIT       7
`define TLV_TC_SENSE0     0
`define TLV_TC_PEND0      1
`define TLV_TC_SENSE1     2
`define TLV_TC_PEND1      3
`define TLV_TC_PEND_T0    5
`define TLV_TC_PEND_T1    7
`define TLV_PC_POL0       3
`define TLV_PC_POL1       7
`define TLV_SRC_EXT0      4'h0
`define TLV_SRC_T0        4'h1
`define TLV_SRC_EXT1      4'h2
`define TLV_SRC_T1        4'h3
`define TLV_EXT_MASK      16'h0005
`define TLV_HWCLR_MASK    16'h000f
`define TLV_VEC_BASE      16'h0003
`define TLV_VEC_SHIFT     3
`define TLV_RST_VECTOR    16'h0000
`define TLV_PIN_IDLE      8'hff
`endif

// >>> hw/tlv_pkg.sv
// Types for the two-level vectored interrupt handler
package tlv_pkg;
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic       level;
    logic       rise;
  } tlv_ext_state_t;

  typedef struct packed {
    logic [15:0] enable;
    logic        globalEn;
    logic [15:0] prio;
    logic [15:0] pending;
    logic [1:0]  sense;
    logic [7:0]  pinCfg;
    logic        inSvcHi;
    logic        inSvcLo;
    logic        retiHold;
    logic        irqReq;
    logic        reqHigh;
    logic [3:0]  srcIdx;
    logic [15:0] vector;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tlv_state_t;
endpackage : tlv_pkg

// >>> hw/tlv_ext_input.sv
// External interrupt pin synchroniser, selector and edge detector
`timescale 1ns/10ps
`default_nettype none
`include "tlv_consts.svh"
module tlv_ext_input
  import tlv_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] portPins,
  input  wire logic [2:0] pinSel,
  input  wire logic       polarityHigh,
  output logic            edgePulse,
  output logic            levelActive
);
  import tlv_pkg::*;

  tlv_ext_state_t q;
  tlv_ext_state_t d;
  logic           active;

  always_comb begin
    d        = q;
    d.sync1  = portPins;
    d.sync2  = q.sync1;
    active   = q.sync2[pinSel] ~^ polarityHigh;
    d.level  = active;
    d.rise   = active & ~q.level;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      // Synchronisers start at the idle pin level, so no false edge follows reset
      q <= '{sync1: `TLV_PIN_IDLE, sync2: `TLV_PIN_IDLE, level: 1'b0, rise: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign edgePulse   = q.rise;
  assign levelActive = q.level;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_EDGE_ONCE: assert property (q.rise |=> !q.rise)
    else $error("Edge pulse lasted more than one cycle");
  AST_EDGE_NEEDS_RISE: assert property (q.rise |-> q.level && !$past(q.level))
    else $error("Edge pulse without an inactive-to-active change");
endmodule : tlv_ext_input
`default_nettype wire

// >>> hw/tlv_irq_handler.sv
// Two-level vectored interrupt handler with APB register access
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tlv_consts.svh"
module tlv_irq_handler
  import tlv_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [15:0] periphEvent,
  input  wire logic [7:0]  portPins,
  input  wire logic        vectorTaken,
  input  wire logic        returnDone,
  input  wire logic        instrEnd,
  output logic             irqReq,
  output logic             irqHigh,
  output logic [3:0]       irqSource,
  output logic [15:0]      irqVector
);
  import tlv_pkg::*;

  tlv_state_t  q;
  tlv_state_t  d;
  logic        ext0Edge;
  logic        ext0Level;
  logic        ext1Edge;
  logic        ext1Level;
  logic        setupPh;
  logic        wrAcc;
  logic        mapped;
  logic [31:0] rdMux;
  logic [15:0] elig;
  logic [15:0] hiReq;
  logic [15:0] loReq;
  logic [15:0] cand;
  logic [3:0]  idx;
  logic [15:0] swSet;
  logic [15:0] swClr;
  logic [15:0] hwClr;
  logic [15:0] evSet;

  tlv_ext_input uExt0 (
    .clk          (clk),
    .nrst         (nrst),
    .portPins     (portPins),
    .pinSel       (q.pinCfg[2:0]),
    .polarityHigh (q.pinCfg[`TLV_PC_POL0]),
    .edgePulse    (ext0Edge),
    .levelActive  (ext0Level)
  );

  tlv_ext_input uExt1 (
    .clk          (clk),
    .nrst         (nrst),
    .portPins     (portPins),
    .pinSel       (q.pinCfg[6:4]),
    .polarityHigh (q.pinCfg[`TLV_PC_POL1]),
    .edgePulse    (ext1Edge),
    .levelActive  (ext1Level)
  );

  always_comb begin
    d       = q;
    setupPh = psel & ~penable;
    wrAcc   = psel & penable & q.pready & pwrite;
    mapped  = 1'b1;
    rdMux   = '0;
    swSet   = '0;
    swClr   = '0;
    hwClr   = '0;
    evSet   = '0;

    // Register read mux
    if (paddr == `TLV_ADDR_EN) begin
      rdMux[7:0] = {q.globalEn, q.enable[6:0]};
    end else if (paddr == `TLV_ADDR_EXT_EN1) begin
      rdMux[7:0] = q.enable[14:7];
    end else if (paddr == `TLV_ADDR_EXT_EN2) begin
      rdMux[0] = q.enable[15];
    end else if (paddr == `TLV_ADDR_PRIO) begin
      rdMux[6:0] = q.prio[6:0];
    end else if (paddr == `TLV_ADDR_EXT_PRI1) begin
      rdMux[7:0] = q.prio[14:7];
    end else if (paddr == `TLV_ADDR_EXT_PRI2) begin
      rdMux[0] = q.prio[15];
    end else if (paddr == `TLV_ADDR_TMR_CTL) begin
      rdMux[`TLV_TC_SENSE0]  = q.sense[0];
      rdMux[`TLV_TC_PEND0]   = q.pending[`TLV_SRC_EXT0];
      rdMux[`TLV_TC_SENSE1]  = q.sense[1];
      rdMux[`TLV_TC_PEND1]   = q.pending[`TLV_SRC_EXT1];
      rdMux[`TLV_TC_PEND_T0] = q.pending[`TLV_SRC_T0];
      rdMux[`TLV_TC_PEND_T1] = q.pending[`TLV_SRC_T1];
    end else if (paddr == `TLV_ADDR_PIN_CFG) begin
      rdMux[7:0] = q.pinCfg;
    end else if (paddr == `TLV_ADDR_PEND_SET || paddr == `TLV_ADDR_PEND_CLR) begin
      rdMux[15:0] = q.pending;
    end else if (paddr == `TLV_ADDR_STATUS) begin
      rdMux[11:0] = {q.inSvcHi, q.inSvcLo, q.retiHold, q.irqReq, q.reqHigh, 3'h0, q.srcIdx};
    end else begin
      mapped = 1'b0;
    end

    // APB zero-wait answer during the access phase
    d.pready  = setupPh;
    d.pslverr = setupPh & ~mapped;
    if (setupPh) begin
      d.prdata = pwrite ? 32'h0000_0000 : rdMux;
    end

    // Register writes
    if (wrAcc && mapped) begin
      if (paddr == `TLV_ADDR_EN) begin
        d.globalEn    = pwdata[`TLV_GEN_BIT];
        d.enable[6:0] = pwdata[6:0];
      end else if (paddr == `TLV_ADDR_EXT_EN1) begin
        d.enable[14:7] = pwdata[7:0];
      end else if (paddr == `TLV_ADDR_EXT_EN2) begin
        d.enable[15] = pwdata[0];
      end else if (paddr == `TLV_ADDR_PRIO) begin
        d.prio[6:0] = pwdata[6:0];
      end else if (paddr == `TLV_ADDR_EXT_PRI1) begin
        d.prio[14:7] = pwdata[7:0];
      end else if (paddr == `TLV_ADDR_EXT_PRI2) begin
        d.prio[15] = pwdata[0];
      end else if (paddr == `TLV_ADDR_TMR_CTL) begin
        d.sense[0] = pwdata[`TLV_TC_SENSE0];
        d.sense[1] = pwdata[`TLV_TC_SENSE1];
        swSet[`TLV_SRC_EXT0] = pwdata[`TLV_TC_PEND0];
        swClr[`TLV_SRC_EXT0] = ~pwdata[`TLV_TC_PEND0];
        swSet[`TLV_SRC_EXT1] = pwdata[`TLV_TC_PEND1];
        swClr[`TLV_SRC_EXT1] = ~pwdata[`TLV_TC_PEND1];
        swSet[`TLV_SRC_T0]   = pwdata[`TLV_TC_PEND_T0];
        swClr[`TLV_SRC_T0]   = ~pwdata[`TLV_TC_PEND_T0];
        swSet[`TLV_SRC_T1]   = pwdata[`TLV_TC_PEND_T1];
        swClr[`TLV_SRC_T1]   = ~pwdata[`TLV_TC_PEND_T1];
      end else if (paddr == `TLV_ADDR_PIN_CFG) begin
        d.pinCfg = pwdata[7:0];
      end else if (paddr == `TLV_ADDR_PEND_SET) begin
        swSet = pwdata[15:0];
      end else if (paddr == `TLV_ADDR_PEND_CLR) begin
        swClr = pwdata[15:0];
      end
    end

    // Arbitration, sampled every cycle
    elig  = q.pending & q.enable & {`TLV_NSRC{q.globalEn}};
    hiReq = elig & q.prio;
    loReq = elig & ~q.prio;
    if (q.inSvcHi) begin
      cand = '0;
    end else if (q.inSvcLo) begin
      cand = hiReq;
    end else if (|hiReq) begin
      cand = hiReq;
    end else begin
      cand = loReq;
    end
    idx = '0;
    for (int i = `TLV_NSRC - 1; i >= 0; i--) begin
      if (cand[i]) begin
        idx = 4'(i);
      end
    end
    d.srcIdx  = idx;
    d.reqHigh = |(cand & q.prio);
    d.vector  = `TLV_VEC_BASE + (16'(idx) << `TLV_VEC_SHIFT);
    // Stale by one cycle, so a request seen as the global enable clears survives one cycle
    d.irqReq  = |cand & ~q.retiHold & ~vectorTaken & ~returnDone;

    // Core takes the long call
    if (vectorTaken && q.irqReq) begin
      if (q.reqHigh) begin
        d.inSvcHi = 1'b1;
      end else begin
        d.inSvcLo = 1'b1;
      end
      hwClr = `TLV_HWCLR_MASK & (16'h0001 << q.srcIdx);
    end

    // Handler return restores the interrupted level
    if (returnDone) begin
      if (q.inSvcHi) begin
        d.inSvcHi = 1'b0;
      end else begin
        d.inSvcLo = 1'b0;
      end
      d.retiHold = 1'b1;
    end else if (instrEnd) begin
      d.retiHold = 1'b0;
    end

    // Pending flags; a set in the same cycle as a clear wins
    evSet = periphEvent & ~`TLV_EXT_MASK;
    evSet[`TLV_SRC_EXT0] = q.sense[0] & ext0Edge;
    evSet[`TLV_SRC_EXT1] = q.sense[1] & ext1Edge;
    d.pending = (q.pending & ~(swClr | hwClr)) | evSet | swSet;
    if (!q.sense[0]) begin
      d.pending[`TLV_SRC_EXT0] = ext0Level;
    end
    if (!q.sense[1]) begin
      d.pending[`TLV_SRC_EXT1] = ext1Level;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pready    = q.pready;
  assign prdata    = q.prdata;
  assign pslverr   = q.pslverr;
  assign irqReq    = q.irqReq;
  assign irqHigh   = q.reqHigh;
  assign irqSource = q.srcIdx;
  assign irqVector = q.vector;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_GLOBAL_MASK: assert property (!q.globalEn && !$past(q.globalEn) |-> !q.irqReq)
    else $error("Request raised with global enable off");
  AST_EVENT_SETS_FLAG: assert property (
    (periphEvent & ~`TLV_EXT_MASK) != 16'h0000 |=>
      (q.pending & $past(periphEvent & ~`TLV_EXT_MASK)) == $past(periphEvent & ~`TLV_EXT_MASK))
    else $error("Peripheral event did not set its pending flag");
  AST_VECTOR_ADDR: assert property (q.irqReq |-> q.vector == `TLV_VEC_BASE + {9'h000, q.srcIdx, 3'h0})
    else $error("Vector address does not match source");
  AST_ONLY_ENABLED: assert property (q.irqReq |-> (($past(elig) >> q.srcIdx) & 16'h0001) != 16'h0000)
    else $error("Request from a source that was not enabled and pending");
  AST_HIGH_NOT_PREEMPTED: assert property (q.inSvcHi && $past(q.inSvcHi) |-> !q.irqReq)
    else $error("High level handler was preempted");
  AST_LOW_ONLY_BY_HIGH: assert property (q.inSvcLo && $past(q.inSvcLo) && q.irqReq |-> q.reqHigh)
    else $error("Low level handler preempted by low request");
  AST_HIGH_WINS: assert property (q.irqReq && !q.reqHigh |-> $past(hiReq) == 16'h0000)
    else $error("Low request chosen while high was eligible");
  AST_RETURN_HOLD: assert property (returnDone |=> !q.irqReq ##1 (!q.irqReq || $past(instrEnd)))
    else $error("Request re-raised before the next instruction ended");
  AST_EDGE_CLEAR: assert property (
    vectorTaken && q.irqReq && q.srcIdx == `TLV_SRC_EXT0 && q.sense[0] && !ext0Edge && !psel
      |=> !q.pending[`TLV_SRC_EXT0])
    else $error("Edge flag not cleared on vectoring");
  AST_LEVEL_FOLLOWS: assert property ($past(!q.sense[0]) |-> q.pending[`TLV_SRC_EXT0] == $past(ext0Level))
    else $error("Level flag does not follow input");
  AST_SW_SET: assert property (wrAcc && paddr == `TLV_ADDR_PEND_SET |=>
    (q.pending & $past(pwdata[15:0] & ~`TLV_EXT_MASK)) == $past(pwdata[15:0] & ~`TLV_EXT_MASK))
    else $error("Software set of a pending flag was lost");
  AST_RESET_LOW_PRIO: assert property ($rose(nrst) |-> q.prio == 16'h0000 && !q.irqReq)
    else $error("Priorities not low after reset");
  AST_TAKE_DROPS_REQ: assert property (vectorTaken |=> !q.irqReq)
    else $error("Request still raised after the long call");
  AST_TAKE_SETS_LOW: assert property (
    vectorTaken && q.irqReq && !q.reqHigh && !returnDone |=> q.inSvcLo)
    else $error("Low level not marked in service");
  AST_TAKE_SETS_HIGH: assert property (vectorTaken && q.irqReq && q.reqHigh |=> q.inSvcHi)
    else $error("High level not marked in service");
  AST_RETURN_POPS_HIGH: assert property (
    returnDone && q.inSvcHi && !vectorTaken |=> !q.inSvcHi && q.inSvcLo == $past(q.inSvcLo))
    else $error("Return did not leave the high level handler");
  AST_RETURN_POPS_LOW: assert property (returnDone && !q.inSvcHi && !vectorTaken |=> !q.inSvcLo)
    else $error("Return did not leave the low level handler");
  AST_HOLD_BLOCKS: assert property (q.retiHold |=> !q.irqReq)
    else $error("Request raised before an instruction followed the return");
  AST_LOWEST_WINS: assert property (
    q.irqReq |-> ($past(cand) & ((16'h0001 << q.srcIdx) - 16'h0001)) == 16'h0000)
    else $error("Request chosen over a lower numbered candidate");
  AST_KEEPS_SW_FLAG: assert property (
    vectorTaken && q.irqReq && q.srcIdx > `TLV_SRC_T1 && !psel |=> q.pending[$past(q.srcIdx)])
    else $error("Software cleared flag was cleared by hardware");
  AST_LEVEL_FOLLOWS1: assert property (
    $past(!q.sense[1]) |-> q.pending[`TLV_SRC_EXT1] == $past(ext1Level))
    else $error("Second level flag does not follow input");
  AST_EDGE_SETS0: assert property (q.sense[0] && ext0Edge |=> q.pending[`TLV_SRC_EXT0])
    else $error("Edge did not set the external flag");
  AST_ENABLE_WRITE: assert property (
    wrAcc && paddr == `TLV_ADDR_EN |=> q.globalEn == $past(pwdata[`TLV_GEN_BIT]))
    else $error("Global enable write lost");
  AST_PRIO_WRITE: assert property (
    wrAcc && paddr == `TLV_ADDR_PRIO |=> q.prio[6:0] == $past(pwdata[6:0]))
    else $error("Priority write lost");

  COV_PREEMPT: cover property (q.inSvcLo && q.irqReq && q.reqHigh);
  COV_RETRIGGER: cover property (returnDone ##[1:20] q.irqReq);
  COV_EXT_EDGE: cover property (ext0Edge && q.sense[0] ##[1:4] q.irqReq && q.srcIdx == `TLV_SRC_EXT0);
  COV_HIGH_TAKEN: cover property (vectorTaken && q.irqReq && q.reqHigh);
  COV_EXT1_LEVEL: cover property (!q.sense[1] && q.pending[`TLV_SRC_EXT1]);
endmodule : tlv_irq_handler
`default_nettype wire

// >>> testbench/tlv_core_model.sv
// Behavioural core sequencer facing the interrupt handler
`timescale 1ns/10ps
`default_nettype none
module tlv_core_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        irqReq,
  input  wire logic [15:0] irqVector,
  input  wire logic        takeEn,
  input  wire logic        retCmd,
  input  wire logic        instrCmd,
  output logic             vectorTaken,
  output logic             returnDone,
  output logic             instrEnd,
  output logic [15:0]      lastVector,
  output logic [1:0]       depth
);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      vectorTaken <= 1'b0;
      returnDone  <= 1'b0;
      instrEnd    <= 1'b0;
      lastVector  <= 16'h0;
      depth       <= 2'h0;
    end else begin
      // Long call only on a standing request, one pulse each
      vectorTaken <= takeEn && irqReq && !vectorTaken;
      // Return only from inside a handler
      returnDone  <= retCmd && (depth != 2'h0);
      instrEnd    <= instrCmd;
      if (vectorTaken) begin
        lastVector <= irqVector;
      end
      if (vectorTaken && !returnDone) begin
        depth <= depth + 2'h1;
      end else if (returnDone && !vectorTaken) begin
        depth <= depth - 2'h1;
      end
    end
  end
endmodule : tlv_core_model
`default_nettype wire

// >>> testbench/two_level_vectored_irq_handler_tb.sv
// Self-checking bench for the two-level vectored interrupt handler
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module two_level_vectored_irq_handler_tb;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, portPins;
  logic [31:0] pwdata, prdata;
  logic [15:0] periphEvent, irqVector, lastVector;
  logic        vectorTaken, returnDone, instrEnd, irqReq, irqHigh;
  logic        takeEn, retCmd, instrCmd;
  logic [3:0]  irqSource;
  logic [1:0]  depth;
  int          errors, n_compared, a;

  tlv_irq_handler i_tlv_irq_handler (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .periphEvent(periphEvent), .portPins(portPins), .vectorTaken(vectorTaken), .returnDone(returnDone),
    .instrEnd(instrEnd), .irqReq(irqReq), .irqHigh(irqHigh), .irqSource(irqSource), .irqVector(irqVector));
  tlv_core_model i_tlv_core_model (.clk(clk), .nrst(nrst), .irqReq(irqReq), .irqVector(irqVector),
    .takeEn(takeEn), .retCmd(retCmd), .instrCmd(instrCmd), .vectorTaken(vectorTaken),
    .returnDone(returnDone), .instrEnd(instrEnd), .lastVector(lastVector), .depth(depth));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic complete_run;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      errors++;
      complete_run();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, ad, d, q, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] ex, input logic exErr);
    logic [31:0] q;
    logic        e;
    apb(1'b0, ad, 32'h0, q, e);
    `CHK("prdata", ex, q)
    `CHK("pslverr", exErr, e)
  endtask : rd_chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wait_req;
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (irqReq === 1'b1) break;
    end
    if (i == 20) begin
      errors++;
      complete_run();
    end
  endtask : wait_req

  task automatic take;
    int i;
    @(posedge clk);
    takeEn <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (vectorTaken === 1'b1) break;
    end
    takeEn <= 1'b0;
    if (i == 20) begin
      errors++;
      complete_run();
    end
  endtask : take

  task automatic pulse(input logic isRet);
    @(posedge clk);
    if (isRet) retCmd <= 1'b1;
    else instrCmd <= 1'b1;
    @(posedge clk);
    retCmd   <= 1'b0;
    instrCmd <= 1'b0;
  endtask : pulse

  task automatic pulse_ev(input int idx);
    @(posedge clk);
    periphEvent <= 16'h1 << idx;
    @(posedge clk);
    periphEvent <= 16'h0;
  endtask : pulse_ev

  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    periphEvent = 16'h0; portPins = 8'hfb; takeEn = 1'b0; retCmd = 1'b0; instrCmd = 1'b0;
    nrst = 1'b0; errors = 0; n_compared = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    for (a = 0; a <= 40; a += 4) rd_chk(8'(a), 32'h0, 1'b0);
    wr(8'h40, 32'hffffffff);
    rd_chk(8'h40, 32'h0, 1'b1);
    pulse_ev(4);
    cyc(2);
    `CHK("irqReq", 1'b0, irqReq)
    rd_chk(8'h20, 32'h10, 1'b0);
    wr(8'h00, 32'h10);
    cyc(3);
    `CHK("irqReq", 1'b0, irqReq)
    wr(8'h00, 32'h90);
    wait_req();
    `CHK("irqVector", 16'h0023, irqVector)
    take();
    cyc(2);
    `CHK("lastVector", 16'h0023, lastVector)
    `CHK("irqReq", 1'b0, irqReq)
    rd_chk(8'h20, 32'h10, 1'b0);
    pulse(1'b1);
    cyc(3);
    `CHK("irqReq", 1'b0, irqReq)
    pulse(1'b0);
    wait_req();
    `CHK("irqVector", 16'h0023, irqVector)
    take();
    wr(8'h24, 32'h10);
    pulse(1'b1);
    pulse(1'b0);
    cyc(3);
    `CHK("irqReq", 1'b0, irqReq)
    wr(8'h00, 32'he0);
    wr(8'h20, 32'h60);
    wait_req();
    `CHK("irqSource", 4'h5, irqSource)
    take();
    wr(8'h24, 32'h20);
    wr(8'h0c, 32'h40);
    wait_req();
    `CHK("irqSource", 4'h6, irqSource)
    `CHK("irqHigh", 1'b1, irqHigh)
    take();
    wr(8'h0c, 32'h60);
    wr(8'h20, 32'h20);
    cyc(3);
    `CHK("irqReq", 1'b0, irqReq)
    wr(8'h24, 32'h60);
    wr(8'h0c, 32'h0);
    pulse(1'b1);
    pulse(1'b0);
    pulse(1'b1);
    pulse(1'b0);
    `CHK("depth", 2'h0, depth)
    rd_chk(8'h28, 32'h0, 1'b0);
    wr(8'h00, 32'h90);
    pulse_ev(4);
    #1 `CHK("irqReq", 1'b0, irqReq)
    @(posedge clk);
    #1 `CHK("irqReq", 1'b1, irqReq)
    take();
    wr(8'h24, 32'h10);
    pulse(1'b1);
    pulse(1'b0);
    wr(8'h18, 32'h01);
    wr(8'h1c, 32'h5a);
    cyc(4);
    rd_chk(8'h18, 32'h01, 1'b0);
    @(posedge clk);
    portPins <= 8'hff;
    cyc(6);
    rd_chk(8'h18, 32'h03, 1'b0);
    wr(8'h18, 32'h01);
    cyc(4);
    rd_chk(8'h18, 32'h01, 1'b0);
    portPins <= 8'hfb;
    cyc(6);
    rd_chk(8'h18, 32'h01, 1'b0);
    wr(8'h00, 32'h81);
    portPins <= 8'hff;
    wait_req();
    `CHK("irqVector", 16'h0003, irqVector)
    take();
    rd_chk(8'h18, 32'h01, 1'b0);
    pulse(1'b1);
    pulse(1'b0);
    portPins <= 8'hdf;
    cyc(6);
    rd_chk(8'h18, 32'h09, 1'b0);
    portPins <= 8'hff;
    cyc(6);
    rd_chk(8'h18, 32'h01, 1'b0);
    wr(8'h20, 32'h01);
    wait_req();
    wr(8'h00, 32'h01);
    #1 `CHK("irqReq", 1'b1, irqReq)
    @(posedge clk);
    #1 `CHK("irqReq", 1'b0, irqReq)
    pulse(1'b0);
    rd_chk(8'h00, 32'h01, 1'b0);
    complete_run();
  end
endmodule : two_level_vectored_irq_handler_tb
`default_nettype wire
